/* File: swm_pkg.sv */
// Behaviour
// - wait reset release interval before next activity
// - read slot: drive low, release, sample in window
// - slots 60-120us, write lows, recovery gap
// - program pulse 480 to 5000us wide
// - summed programming per address capped 5ms
// - reset low at least 480us, then listen
// - every slot starts with master falling edge
package swm_pkg;
    localparam int unsigned CLK_MHZ           = 100;
    localparam int unsigned RESET_LOW_US      = 480;
    localparam int unsigned RESET_RELEASE_US  = 480;
    localparam int unsigned PRESENCE_SAMPLE_US = 70;
    localparam int unsigned SLOT_US           = 70;
    localparam int unsigned ONE_LOW_US        = 6;
    localparam int unsigned ZERO_LOW_US       = 60;
    localparam int unsigned READ_LOW_US       = 2;
    localparam int unsigned READ_SAMPLE_US    = 12;
    localparam int unsigned READ_WINDOW_US    = 15;
    localparam int unsigned RECOVERY_US       = 5;
    localparam int unsigned PROG_DELAY_US     = 5;
    localparam int unsigned VERIFY_DELAY_US   = 5;
    localparam int unsigned PROG_MIN_US       = 480;
    localparam int unsigned PROG_MAX_US       = 5000;
    localparam int unsigned PROG_BUDGET_US    = 5000;
    localparam int unsigned RESET_LOW_CYC     = RESET_LOW_US * CLK_MHZ;
    localparam int unsigned RESET_REL_CYC     = RESET_RELEASE_US * CLK_MHZ;
    localparam int unsigned PRES_SAMPLE_CYC   = PRESENCE_SAMPLE_US * CLK_MHZ;
    localparam int unsigned SLOT_CYC          = SLOT_US * CLK_MHZ;
    localparam int unsigned ONE_LOW_CYC       = ONE_LOW_US * CLK_MHZ;
    localparam int unsigned ZERO_LOW_CYC      = ZERO_LOW_US * CLK_MHZ;
    localparam int unsigned READ_LOW_CYC      = READ_LOW_US * CLK_MHZ;
    localparam int unsigned READ_SAMPLE_CYC   = READ_SAMPLE_US * CLK_MHZ;
    localparam int unsigned READ_WINDOW_CYC   = READ_WINDOW_US * CLK_MHZ;
    localparam int unsigned RECOVERY_CYC      = RECOVERY_US * CLK_MHZ;
    localparam int unsigned PROG_DELAY_CYC    = PROG_DELAY_US * CLK_MHZ;
    localparam int unsigned VERIFY_DELAY_CYC  = VERIFY_DELAY_US * CLK_MHZ;
    localparam int unsigned PROG_MIN_CYC      = PROG_MIN_US * CLK_MHZ;
    localparam int unsigned PROG_MAX_CYC      = PROG_MAX_US * CLK_MHZ;
    localparam int unsigned PROG_BUDGET_CYC   = PROG_BUDGET_US * CLK_MHZ;
    localparam int unsigned CNT_W             = 20;
    localparam int unsigned ADDR_W            = 7;
    localparam logic [2:0] OP_RESET = 3'h0;
    localparam logic [2:0] OP_WR1   = 3'h1;
    localparam logic [2:0] OP_WR0   = 3'h2;
    localparam logic [2:0] OP_READ  = 3'h3;
    localparam logic [2:0] OP_PROG  = 3'h4;
    typedef enum logic [5:0] {
        SWM_IDLE    = 6'h01,
        SWM_LOW     = 6'h02,
        SWM_HIGH    = 6'h04,
        SWM_PREGAP  = 6'h08,
        SWM_PULSE   = 6'h10,
        SWM_POSTGAP = 6'h20
    } swm_state_t;
endpackage

/* File: swm_budget_if.sv */
`timescale 1ns/100ps
interface swm_budget_if;
    import swm_pkg::*;
    logic              clear;
    logic              charge;
    logic [ADDR_W-1:0] addr;
    logic [CNT_W+2:0]  need;
    logic              allow;
    modport ctl (output clear, output charge, output addr, output need, input allow);
    modport bud (input clear, input charge, input addr, input need, output allow);
endinterface

/* File: swm_budget.sv */
`timescale 1ns/100ps
// per-address accumulated programming time
module swm_budget
    import swm_pkg::*;
#(
    parameter int unsigned ENTRIES    = 1 << ADDR_W,
    parameter int unsigned BUDGET_CYC = PROG_BUDGET_CYC
) (
    input  wire logic clk,
    input  wire logic reset_n,
    swm_budget_if.bud bif
);
    logic [CNT_W+2:0] used_q [ENTRIES];
    logic [CNT_W+2:0] used_d [ENTRIES];
    logic             allow_d;

    // charge adds one cycle to the selected address
    always_comb begin
        for (int i = 0; i < ENTRIES; i++) begin
            used_d[i] = used_q[i];
        end
        if (bif.clear) begin
            for (int i = 0; i < ENTRIES; i++) begin
                used_d[i] = '0;
            end
        end
        // a charge in the clearing cycle still counts
        if (bif.charge) begin
            used_d[bif.addr] = used_d[bif.addr] + (CNT_W+3)'(1);
        end
        allow_d = (used_q[bif.addr] + bif.need) <= (CNT_W+3)'(BUDGET_CYC);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < ENTRIES; i++) begin
                used_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < ENTRIES; i++) begin
                used_q[i] <= used_d[i];
            end
        end
    end

    assign bif.allow = allow_d;

    chk_budget_capped: assert property (@(posedge clk) disable iff (!reset_n)
        used_q[bif.addr] <= (CNT_W+3)'(BUDGET_CYC))
        else $error("programming budget exceeded");
endmodule

/* File: swm_master.sv */
`timescale 1ns/100ps
// single-wire bus master: reset, bit slots and program pulse
module swm_master
    import swm_pkg::*;
#(
    parameter int unsigned CYC_PER_US = CLK_MHZ
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              cmd_valid,
    input  wire logic [2:0]        cmd_op,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    input  wire logic [CNT_W-1:0]  cmd_prog_cycles,
    input  wire logic              budget_clear,
    output logic                   cmd_ready,
    output logic                   done,
    output logic                   rd_bit,
    output logic                   presence,
    output logic                   prog_refused,
    input  wire logic              line_i,
    output logic                   line_o,
    output logic                   line_oe,
    output logic                   prog_en
);
    // timing counts at the chosen clock rate
    localparam int unsigned RST_LOW_N  = RESET_LOW_US * CYC_PER_US;
    localparam int unsigned RST_REL_N  = RESET_RELEASE_US * CYC_PER_US;
    localparam int unsigned PRES_N     = PRESENCE_SAMPLE_US * CYC_PER_US;
    localparam int unsigned SLOT_N     = SLOT_US * CYC_PER_US;
    localparam int unsigned ONE_LOW_N  = ONE_LOW_US * CYC_PER_US;
    localparam int unsigned ZERO_LOW_N = ZERO_LOW_US * CYC_PER_US;
    localparam int unsigned READ_LOW_N = READ_LOW_US * CYC_PER_US;
    localparam int unsigned READ_SMP_N = READ_SAMPLE_US * CYC_PER_US;
    localparam int unsigned REC_N      = RECOVERY_US * CYC_PER_US;
    localparam int unsigned PDLY_N     = PROG_DELAY_US * CYC_PER_US;
    localparam int unsigned VDLY_N     = VERIFY_DELAY_US * CYC_PER_US;
    localparam int unsigned PMIN_N     = PROG_MIN_US * CYC_PER_US;
    localparam int unsigned PMAX_N     = PROG_MAX_US * CYC_PER_US;
    localparam int unsigned BUDGET_N   = PROG_BUDGET_US * CYC_PER_US;

    swm_budget_if bif();

    swm_state_t       state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] plen_q, plen_d;
    logic [2:0]       op_q, op_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic             ready_q, ready_d;
    logic             done_q, done_d;
    logic             bit_q, bit_d;
    logic             pres_q, pres_d;
    logic             refuse_q, refuse_d;
    logic             oe_q, oe_d;
    logic             prog_q, prog_d;
    logic [CNT_W-1:0] req_len;

    // low time of the slot for an operation
    function automatic logic [CNT_W-1:0] low_len(input logic [2:0] op);
        case (op)
            OP_RESET: low_len = CNT_W'(RST_LOW_N);
            OP_WR1:   low_len = CNT_W'(ONE_LOW_N);
            OP_WR0:   low_len = CNT_W'(ZERO_LOW_N);
            default:  low_len = CNT_W'(READ_LOW_N);
        endcase
    endfunction

    // whole time from falling edge to next allowed falling edge
    function automatic logic [CNT_W-1:0] total_len(input logic [2:0] op);
        case (op)
            OP_RESET: total_len = CNT_W'(RST_LOW_N + RST_REL_N);
            default:  total_len = CNT_W'(SLOT_N + REC_N);
        endcase
    endfunction

    // clamp requested pulse width into legal range
    always_comb begin
        if (cmd_prog_cycles < CNT_W'(PMIN_N)) begin
            req_len = CNT_W'(PMIN_N);
        end else if (cmd_prog_cycles > CNT_W'(PMAX_N)) begin
            req_len = CNT_W'(PMAX_N);
        end else begin
            req_len = cmd_prog_cycles;
        end
    end

    assign bif.clear  = budget_clear;
    assign bif.charge = (state_q == SWM_PULSE);
    assign bif.addr   = (state_q == SWM_IDLE) ? cmd_addr : addr_q;
    assign bif.need   = (CNT_W+3)'(req_len);

    // sequencer next state
    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q + CNT_W'(1);
        plen_d   = plen_q;
        op_d     = op_q;
        addr_d   = addr_q;
        ready_d  = 1'b0;
        done_d   = 1'b0;
        bit_d    = bit_q;
        pres_d   = pres_q;
        refuse_d = 1'b0;
        oe_d     = oe_q;
        prog_d   = 1'b0;
        case (state_q)
            SWM_IDLE: begin
                ready_d = 1'b1;
                cnt_d   = '0;
                if (cmd_valid && ready_q) begin
                    ready_d = 1'b0;
                    op_d    = cmd_op;
                    addr_d  = cmd_addr;
                    plen_d  = req_len;
                    if (cmd_op == OP_PROG) begin
                        if (bif.allow) begin
                            state_d = SWM_PREGAP;
                        end else begin
                            refuse_d = 1'b1;
                            done_d   = 1'b1;
                            ready_d  = 1'b1;
                        end
                    end else begin
                        state_d = SWM_LOW;
                        oe_d    = 1'b1;
                    end
                end
            end
            SWM_LOW: begin
                if (cnt_q == low_len(op_q) - CNT_W'(1)) begin
                    oe_d    = 1'b0;
                    state_d = SWM_HIGH;
                end
            end
            SWM_HIGH: begin
                if (op_q == OP_READ && cnt_q == CNT_W'(READ_SMP_N)) begin
                    bit_d = line_i;
                end
                if (op_q == OP_RESET && cnt_q == CNT_W'(RST_LOW_N + PRES_N)) begin
                    pres_d = !line_i;
                end
                if (cnt_q == total_len(op_q) - CNT_W'(1)) begin
                    state_d = SWM_IDLE;
                    done_d  = 1'b1;
                    ready_d = 1'b1;
                end
            end
            SWM_PREGAP: begin
                if (cnt_q == CNT_W'(PDLY_N - 1)) begin
                    state_d = SWM_PULSE;
                    cnt_d   = '0;
                    prog_d  = 1'b1;
                end
            end
            SWM_PULSE: begin
                prog_d = 1'b1;
                if (cnt_q == plen_q - CNT_W'(1)) begin
                    prog_d  = 1'b0;
                    state_d = SWM_POSTGAP;
                    cnt_d   = '0;
                end
            end
            SWM_POSTGAP: begin
                if (cnt_q == CNT_W'(VDLY_N - 1)) begin
                    state_d = SWM_IDLE;
                    done_d  = 1'b1;
                    ready_d = 1'b1;
                end
            end
            default: begin
                state_d = SWM_IDLE;
                oe_d    = 1'b0;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q  <= SWM_IDLE;
            cnt_q    <= '0;
            plen_q   <= '0;
            op_q     <= OP_RESET;
            addr_q   <= '0;
            ready_q  <= 1'b0;
            done_q   <= 1'b0;
            bit_q    <= 1'b0;
            pres_q   <= 1'b0;
            refuse_q <= 1'b0;
            oe_q     <= 1'b0;
            prog_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            plen_q   <= plen_d;
            op_q     <= op_d;
            addr_q   <= addr_d;
            ready_q  <= ready_d;
            done_q   <= done_d;
            bit_q    <= bit_d;
            pres_q   <= pres_d;
            refuse_q <= refuse_d;
            oe_q     <= oe_d;
            prog_q   <= prog_d;
        end
    end

    swm_budget #(
        .BUDGET_CYC (BUDGET_N)
    ) u_budget (
        .clk     (clk),
        .reset_n (reset_n),
        .bif     (bif)
    );

    assign cmd_ready    = ready_q;
    assign done         = done_q;
    assign rd_bit       = bit_q;
    assign presence     = pres_q;
    assign prog_refused = refuse_q;
    assign line_o       = 1'b0;
    assign line_oe      = oe_q;
    assign prog_en      = prog_q;

    sequence s_reset_low;
        oe_q [*8];
    endsequence

    chk_reset_low_len: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(oe_q) && op_q == OP_RESET |-> s_reset_low)
        else $error("reset low too short");
    chk_reset_low_count: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(oe_q) && op_q == OP_RESET |-> cnt_q == CNT_W'(RST_LOW_N))
        else $error("reset low length wrong");
    chk_one_low_len: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(oe_q) && op_q == OP_WR1 |-> cnt_q == CNT_W'(ONE_LOW_N))
        else $error("write one low time wrong");
    chk_zero_low_len: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(oe_q) && op_q == OP_WR0 |-> cnt_q == CNT_W'(ZERO_LOW_N))
        else $error("write zero low time wrong");
    chk_read_release: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(oe_q) && op_q == OP_READ |-> cnt_q < CNT_W'(READ_SMP_N))
        else $error("read slot not released before sample");
    chk_slot_gap: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(state_q == SWM_HIGH) |-> $past(cnt_q) == total_len(op_q) - CNT_W'(1))
        else $error("next slot too early");
    chk_prog_width: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(prog_q) |-> $past(cnt_q) >= CNT_W'(PMIN_N - 1))
        else $error("program pulse too short");
    chk_prog_pregap: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(prog_q) |-> $past(state_q) == SWM_PREGAP && !oe_q)
        else $error("program pulse without delay");
    chk_line_idle_prog: assert property (@(posedge clk) disable iff (!reset_n)
        prog_q |-> !oe_q)
        else $error("line driven during program pulse");
endmodule

/* File: swm_dev_model.sv */
`timescale 1ns/100ps
// behavioural slave device on the shared line, clockless
module swm_dev_model #(
    parameter real US_NS = 1000.0 // nanoseconds per device microsecond
) (
    input  wire logic line,
    input  wire logic dev_on,
    input  wire logic rd_mode,
    input  wire logic dev_bit,
    output logic      pull,
    output logic      wr_bit
);
    realtime t_fall;
    // slot actions are timed from the master's falling edge, the presence pulse from the line's return high
    initial begin
        pull = 1'b0;
        wr_bit = 1'b0;
        forever begin
            @(negedge line);
            t_fall = $realtime;
            if (dev_on === 1'b1) begin
                #(0.5 * US_NS);
                if (rd_mode === 1'b1 && dev_bit === 1'b0) pull = 1'b1;
                #(14.5 * US_NS);
                pull = 1'b0;
                #(15.0 * US_NS);
                wr_bit = line;
                wait (line === 1'b1);
                // long low seen: answer with presence after a short wait
                if ($realtime - t_fall >= 480.0 * US_NS) begin
                    #(30.0 * US_NS);
                    pull = 1'b1;
                    #(120.0 * US_NS);
                    pull = 1'b0;
                end
            end
        end
    end
endmodule

/* File: tb_top.sv */
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin num_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
    import swm_pkg::*;
    // master timed as if 5 cycles per microsecond: keeps the run short
    localparam int unsigned US = 5;
    logic              clk, reset_n, cmd_valid, budget_clear, dev_on, rd_mode, dev_bit;
    logic [2:0]        cmd_op;
    logic [ADDR_W-1:0] cmd_addr;
    logic [CNT_W-1:0]  cmd_prog_cycles;
    logic              cmd_ready, done, rd_bit, presence, prog_refused;
    logic              line_o, line_oe, prog_en, dev_pull, dev_wr_bit, refused;
    wire logic         line;
    int                num_errors, checks_done, oe_cyc, prog_cyc, head, tail, total;

    // pull-up wins unless someone pulls low
    assign line = ~((line_oe & ~line_o) | dev_pull);

    swm_master #(.CYC_PER_US(US)) u_swm_master (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_prog_cycles(cmd_prog_cycles), .budget_clear(budget_clear),
        .cmd_ready(cmd_ready), .done(done), .rd_bit(rd_bit), .presence(presence),
        .prog_refused(prog_refused), .line_i(line), .line_o(line_o), .line_oe(line_oe), .prog_en(prog_en));

    swm_dev_model #(.US_NS(10.0 * US)) u_swm_dev_model (.line(line), .dev_on(dev_on), .rd_mode(rd_mode),
        .dev_bit(dev_bit),
        .pull(dev_pull), .wr_bit(dev_wr_bit));

    // clock source
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic final_report();
        if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // one request, then count line activity until done
    task automatic run_op(input logic [2:0] op, input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] w);
        int i;
        oe_cyc = 0;
        prog_cyc = 0;
        head = -1;
        tail = 0;
        total = 0;
        @(negedge clk);
        `CHK("ready", 1'b1, cmd_ready)
        cmd_op = op;
        cmd_addr = a;
        cmd_prog_cycles = w;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        for (i = 0; i < 30000 && done !== 1'b1; i++) begin
            total++;
            if (line_oe === 1'b1 || prog_en === 1'b1) begin
                if (head < 0) head = total;
                tail = 0;
            end else tail++;
            oe_cyc += int'(line_oe === 1'b1);
            prog_cyc += int'(prog_en === 1'b1);
            @(negedge clk);
        end
        refused = prog_refused;
        if (done !== 1'b1) begin
            num_errors++;
            final_report();
        end
    endtask

    task automatic t_reset(input logic pres);
        dev_on = pres;
        run_op(OP_RESET, '0, '0);
        `CHK("presence", pres, presence)
        `CHK("reset_low", 1'b1, oe_cyc >= 480 * US)
        `CHK("reset_release", 1'b1, tail >= 480 * US)
    endtask

    task automatic t_write(input logic b);
        run_op(b ? OP_WR1 : OP_WR0, '0, '0);
        `CHK("wr_bit", b, dev_wr_bit)
        if (b) `CHK("low1", 1'b1, oe_cyc >= US && oe_cyc < 15 * US)
        else `CHK("low0", 1'b1, oe_cyc >= 60 * US && oe_cyc < total - US)
        `CHK("slot", 1'b1, total >= 61 * US && total < 120 * US)
    endtask

    task automatic t_read(input logic b);
        dev_bit = b;
        rd_mode = 1'b1;
        run_op(OP_READ, '0, '0);
        rd_mode = 1'b0;
        `CHK("rd_bit", b, rd_bit)
        `CHK("read_low", 1'b1, oe_cyc >= US && oe_cyc < 15 * US)
    endtask

    task automatic t_prog(input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] w, input int exp_w);
        run_op(OP_PROG, a, w);
        `CHK("refused", exp_w == 0, refused)
        `CHK("pulse_width", exp_w, prog_cyc)
        if (exp_w > 0) begin
            `CHK("pre_gap", 1'b1, head >= 5 * US)
            `CHK("post_gap", 1'b1, tail >= 5 * US)
            `CHK("no_low", 0, oe_cyc)
        end
    endtask

    // main sequence
    initial begin
        reset_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = 3'h0;
        cmd_addr = '0;
        cmd_prog_cycles = '0;
        budget_clear = 1'b0;
        dev_on = 1'b1;
        rd_mode = 1'b0;
        dev_bit = 1'b1;
        num_errors = 0;
        checks_done = 0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        `CHK("oe_in_reset", 1'b0, line_oe)
        reset_n = 1'b1;
        @(negedge clk);
        t_reset(1'b0);
        t_reset(1'b1);
        t_write(1'b1);
        t_write(1'b0);
        t_read(1'b0);
        t_read(1'b1);
        t_prog(7'h05, 20'h00064, 480 * US);
        t_prog(7'h06, CNT_W'(5000 * US), 5000 * US);
        t_prog(7'h06, CNT_W'(480 * US), 0);
        t_prog(7'h05, 20'hfffff, 0);
        @(negedge clk);
        budget_clear = 1'b1;
        repeat (2) @(negedge clk);
        budget_clear = 1'b0;
        t_prog(7'h06, CNT_W'(480 * US), 480 * US);
        final_report();
    end
endmodule
